// ### fcs_pkg.sv
// package: constants and types for the flash command sequencer
package fcs_pkg;
  // ---------------------------------------------------------------
  // sizes and addresses
  // ---------------------------------------------------------------
  localparam int          FLASH_BYTES   = 8192;
  localparam int          FADDR_W       = 20;
  localparam logic [19:0] WIN0_LO       = 20'h04000;
  localparam logic [19:0] WIN0_HI       = 20'h05eff;
  localparam logic [19:0] WIN1_LO       = 20'hfff00;
  localparam logic [19:0] WIN1_HI       = 20'hfffff;
  localparam int          WIN0_BYTES    = 7936;
  localparam logic [19:0] UNLOCK_A      = 20'h04555;
  localparam logic [19:0] UNLOCK_B      = 20'h04aaa;
  localparam logic [19:0] SECURE_ADDR   = 20'h04f7f;
  localparam logic [19:0] ID_VENDOR_A   = 20'h04000;
  localparam logic [19:0] ID_MACRO_A    = 20'h04001;
  localparam logic [19:0] ID_SIZE_A     = 20'h04002;
  localparam int          SECT_LSB      = 12;
  // ---------------------------------------------------------------
  // command data bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] D_UNLOCK1   = 8'haa;
  localparam logic [7:0] D_UNLOCK2   = 8'h55;
  localparam logic [7:0] C_PROGRAM   = 8'ha0;
  localparam logic [7:0] C_ERASE     = 8'h80;
  localparam logic [7:0] C_SECTOR    = 8'h30;
  localparam logic [7:0] C_CHIP      = 8'h10;
  localparam logic [7:0] C_ID_ENTRY  = 8'h90;
  localparam logic [7:0] C_ID_EXIT   = 8'hf0;
  localparam logic [7:0] C_SECURITY  = 8'ha5;
  localparam logic [7:0] D_SECURE    = 8'h00;
  localparam logic [7:0] ERASED      = 8'hff;
  localparam logic [7:0] SIZE_CODE   = 8'h01;
  // identity values are arbitrary
  localparam logic [7:0] VENDOR_ID   = 8'h5a;
  localparam logic [7:0] MACRO_ID    = 8'h3c;
  localparam int         TOGGLE_BIT  = 6;
  // ---------------------------------------------------------------
  // key field
  // ---------------------------------------------------------------
  localparam logic [3:0] KEY_ENABLE  = 4'h3;
  localparam logic [3:0] KEY_DISABLE = 4'hc;
  localparam int         KEY_LSB     = 4;
  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_FADDR   = 8'h08;
  localparam logic [7:0] REG_FWDATA  = 8'h0c;
  localparam logic [7:0] REG_FCMD    = 8'h10;
  localparam logic [7:0] REG_FRDATA  = 8'h14;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 50000000;
  localparam int PROG_US     = 40;
  localparam int ERASE_MS    = 30;
  localparam int PROG_CYC    = PROG_US * (CLK_HZ / 1000000);
  localparam int ERASE_CYC   = ERASE_MS * (CLK_HZ / 1000);
  localparam int TIMER_W     = 21;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE   = 3'd0,
    OP_PROG   = 3'd1,
    OP_SECTOR = 3'd2,
    OP_CHIP   = 3'd3,
    OP_SECURE = 3'd4
  } fcs_op_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [19:0] addr;
    logic [7:0]  data;
  } fcs_cyc_t;
  typedef struct packed {
    logic        start;
    fcs_op_t     op;
    logic [19:0] addr;
    logic [7:0]  data;
  } fcs_job_t;
endpackage

// ### fcs_timer.sv
// busy timer: counts one operation's duration
`timescale 1ns/1ps
module fcs_timer (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       ce,
  input  wire logic                       start,
  input  wire logic [fcs_pkg::TIMER_W-1:0] count,
  output logic                            busy,
  output logic                            done
);
  logic [fcs_pkg::TIMER_W-1:0] cnt_q;
  logic [fcs_pkg::TIMER_W-1:0] cnt_d;
  logic                        busy_q;
  logic                        busy_d;
  logic                        done_q;
  logic                        done_d;

  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d  = count;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q <= fcs_pkg::TIMER_W'(1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - fcs_pkg::TIMER_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
endmodule

// ### fcs_array.sv
// flash array storage with program and erase operations
`timescale 1ns/1ps
module fcs_array (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire fcs_pkg::fcs_job_t    job,
  input  wire logic                 finish,
  input  wire logic [12:0]          raddr,
  output logic [7:0]                rdata,
  output logic                      secured
);
  logic [7:0]  mem_q [fcs_pkg::FLASH_BYTES];
  logic        secured_q;
  logic        secured_d;
  logic [7:0]  rdata_q;
  logic [12:0] sect_base;

  assign sect_base = {job.addr[fcs_pkg::SECT_LSB], 12'h000};

  // chip erase clears the security setting
  always_comb begin
    secured_d = secured_q;
    if (finish && job.op == fcs_pkg::OP_CHIP) begin
      secured_d = 1'b0;
    end else if (finish && job.op == fcs_pkg::OP_SECURE) begin
      secured_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      secured_q <= 1'b0;
      rdata_q   <= 8'h00;
    end else if (ce) begin
      secured_q <= secured_d;
      rdata_q   <= mem_q[raddr];
    end
  end

  // storage: program clears bits only, erase sets them back; erases land as
  // the operation finishes, so no stale byte is read after completion; the
  // model leaves reset erased so that a first program has a defined result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < fcs_pkg::FLASH_BYTES; i++) begin
        mem_q[i] <= fcs_pkg::ERASED;
      end
    end else if (ce && finish) begin
      if (job.op == fcs_pkg::OP_CHIP) begin
        for (int i = 0; i < fcs_pkg::FLASH_BYTES; i++) begin
          mem_q[i] <= fcs_pkg::ERASED;
        end
      end else if (job.op == fcs_pkg::OP_PROG) begin
        mem_q[raddr] <= mem_q[raddr] & job.data;
      end else if (job.op == fcs_pkg::OP_SECTOR) begin
        for (int i = 0; i < (1 << fcs_pkg::SECT_LSB); i++) begin
          if (int'(sect_base) + i < fcs_pkg::FLASH_BYTES) begin
            mem_q[13'(int'(sect_base) + i)] <= fcs_pkg::ERASED;
          end
        end
      end
    end
  end

  assign rdata   = rdata_q;
  assign secured = secured_q;
endmodule

// ### fcs_top.sv
// flash command sequencer with axi4-lite register access
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module fcs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             flash_busy
);
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    S_IDLE  = 8'b0000_0001,
    S_U1    = 8'b0000_0010,
    S_U2    = 8'b0000_0100,
    S_PROG  = 8'b0000_1000,
    S_E1    = 8'b0001_0000,
    S_E2    = 8'b0010_0000,
    S_E3    = 8'b0100_0000,
    S_SEC   = 8'b1000_0000
  } fcs_state_t;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic        aw_ok_q, aw_ok_d;
  logic [7:0]  aw_q, aw_d;
  logic        w_ok_q, w_ok_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0]  ws_q, ws_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  logic        rd_pend_q, rd_pend_d;
  logic        do_wr;
  logic        do_rd;

  assign s_axi_awready = ce && !aw_ok_q && !bvalid_q;
  assign s_axi_wready  = ce && !w_ok_q && !bvalid_q;
  assign s_axi_arready = ce && !rvalid_q && !rd_pend_q;
  assign do_wr = aw_ok_q && w_ok_q && !bvalid_q;
  assign do_rd = s_axi_arvalid && s_axi_arready;

  // ---------------------------------------------------------------
  // software-visible registers
  // ---------------------------------------------------------------
  logic [3:0]  key_q, key_d;
  logic [19:0] faddr_q, faddr_d;
  logic [7:0]  fwdata_q, fwdata_d;
  logic [7:0]  frdata_q, frdata_d;
  fcs_pkg::fcs_cyc_t cyc;

  // ---------------------------------------------------------------
  // sequencer and operation state
  // ---------------------------------------------------------------
  fcs_state_t        st_q, st_d;
  logic              id_mode_q, id_mode_d;
  logic              tog_q, tog_d;
  fcs_pkg::fcs_job_t job_q, job_d;
  logic [fcs_pkg::TIMER_W-1:0] tcount;
  logic              busy;
  logic              done;
  logic              in_win;
  logic [12:0]       arr_idx;
  logic [12:0]       raddr;
  logic [7:0]        arr_rdata;
  logic              secured;
  logic              rd_phase_q, rd_phase_d;
  logic [7:0]        fl_read;

  always_comb begin
    in_win  = 1'b0;
    arr_idx = 13'h0000;
    if (cyc.addr >= fcs_pkg::WIN0_LO && cyc.addr <= fcs_pkg::WIN0_HI) begin
      in_win  = 1'b1;
      arr_idx = 13'(cyc.addr - fcs_pkg::WIN0_LO);
    end else if (cyc.addr >= fcs_pkg::WIN1_LO) begin
      in_win  = 1'b1;
      arr_idx = 13'(cyc.addr - fcs_pkg::WIN1_LO) + 13'(fcs_pkg::WIN0_BYTES);
    end
  end

  // flash cycle made from software writing the command register
  always_comb begin
    cyc.wr   = do_wr && aw_q == fcs_pkg::REG_FCMD && ws_q[0] && wd_q[0];
    cyc.rd   = do_wr && aw_q == fcs_pkg::REG_FCMD && ws_q[0] && wd_q[1];
    cyc.addr = faddr_q;
    cyc.data = fwdata_q;
  end

  // the job address stays on the array port through the finishing cycle
  assign raddr = job_q.start || busy || done ? job_q.addr[12:0] : arr_idx;

  always_comb begin
    if (job_q.op == fcs_pkg::OP_SECTOR || job_q.op == fcs_pkg::OP_CHIP) begin
      tcount = fcs_pkg::TIMER_W'(fcs_pkg::ERASE_CYC);
    end else begin
      tcount = fcs_pkg::TIMER_W'(fcs_pkg::PROG_CYC);
    end
  end

  fcs_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .start   (job_q.start),
    .count   (tcount),
    .busy    (busy),
    .done    (done)
  );

  // chip erase sets every byte to ff
  fcs_array u_array (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .job     (job_q),
    .finish  (done),
    .raddr   (raddr),
    .rdata   (arr_rdata),
    .secured (secured)
  );

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    id_mode_d = id_mode_q;
    job_d     = job_q;
    job_d.start = 1'b0;
    // cycles ignored while an operation runs
    // key gates decode in cpu modes
    if (cyc.wr && !busy && !job_q.start && key_q == fcs_pkg::KEY_ENABLE && in_win) begin
      st_d = S_IDLE;
      if (cyc.data == fcs_pkg::C_ID_EXIT && st_q != S_U2) begin
        id_mode_d = 1'b0;
      end
      case (st_q)
        S_IDLE, S_E3: begin
          if (cyc.addr == fcs_pkg::UNLOCK_A && cyc.data == fcs_pkg::D_UNLOCK1) begin
            st_d = st_q == S_IDLE ? S_U1 : S_E1;
          end
        end
        S_U1, S_E1: begin
          if (cyc.addr == fcs_pkg::UNLOCK_B && cyc.data == fcs_pkg::D_UNLOCK2) begin
            st_d = st_q == S_U1 ? S_U2 : S_E2;
          end
        end
        S_U2: begin
          if (cyc.addr == fcs_pkg::UNLOCK_A) begin
            if (cyc.data == fcs_pkg::C_PROGRAM) begin
              st_d = S_PROG;
            end else if (cyc.data == fcs_pkg::C_ERASE) begin
              st_d = S_E3;
            end else if (cyc.data == fcs_pkg::C_ID_ENTRY) begin
              id_mode_d = 1'b1;
            end else if (cyc.data == fcs_pkg::C_ID_EXIT) begin
              id_mode_d = 1'b0;
            end else if (cyc.data == fcs_pkg::C_SECURITY) begin
              st_d = S_SEC;
            end
          end
        end
        S_PROG: begin
          job_d = '{start: 1'b1, op: fcs_pkg::OP_PROG, addr: 20'(arr_idx), data: cyc.data};
        end
        // sector erase by upper address bit
        S_E2: begin
          if (cyc.data == fcs_pkg::C_SECTOR) begin
            job_d = '{start: 1'b1, op: fcs_pkg::OP_SECTOR, addr: 20'(arr_idx), data: 8'h00};
          end else if (cyc.data == fcs_pkg::C_CHIP && cyc.addr == fcs_pkg::UNLOCK_A) begin
            job_d = '{start: 1'b1, op: fcs_pkg::OP_CHIP, addr: 20'h00000, data: 8'h00};
          end
        end
        S_SEC: begin
          if (cyc.addr == fcs_pkg::SECURE_ADDR && cyc.data == fcs_pkg::D_SECURE) begin
            job_d = '{start: 1'b1, op: fcs_pkg::OP_SECURE, addr: 20'h00000, data: 8'h00};
          end
        end
        default: st_d = S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // flash read path
  // ---------------------------------------------------------------
  always_comb begin
    fl_read = arr_rdata;
    if (busy) begin
      fl_read = 8'h00;
      fl_read[fcs_pkg::TOGGLE_BIT] = tog_q;
    end else if (id_mode_q) begin
      if (cyc.addr == fcs_pkg::ID_VENDOR_A) begin
        fl_read = fcs_pkg::VENDOR_ID;
      end else if (cyc.addr == fcs_pkg::ID_MACRO_A) begin
        fl_read = fcs_pkg::MACRO_ID;
      end else if (cyc.addr == fcs_pkg::ID_SIZE_A) begin
        fl_read = fcs_pkg::SIZE_CODE;
      end else if (cyc.addr == fcs_pkg::SECURE_ADDR) begin
        fl_read = secured ? fcs_pkg::D_SECURE : fcs_pkg::ERASED;
      end
    end
  end

  always_comb begin
    tog_d      = tog_q;
    rd_phase_d = 1'b0;
    frdata_d   = frdata_q;
    if (job_q.start) begin
      tog_d = 1'b1;
    end
    if (cyc.rd && in_win) begin
      rd_phase_d = 1'b1;
    end
    if (rd_phase_q) begin
      frdata_d = fl_read;
      if (busy) begin
        tog_d = ~tog_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // bus channels and register writes
  // ---------------------------------------------------------------
  always_comb begin
    aw_ok_d = aw_ok_q;
    aw_d    = aw_q;
    w_ok_d  = w_ok_q;
    wd_d    = wd_q;
    ws_d    = ws_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    key_d    = key_q;
    faddr_d  = faddr_q;
    fwdata_d = fwdata_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_d = 1'b1;
      aw_d    = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_ok_d = 1'b1;
      wd_d   = s_axi_wdata;
      ws_d   = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_ok_d  = 1'b0;
      w_ok_d   = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = fcs_pkg::RESP_OKAY;
      if (aw_q == fcs_pkg::REG_CTRL) begin
        // only the two key values are stored
        if (ws_q[0] && (wd_q[7:4] == fcs_pkg::KEY_ENABLE || wd_q[7:4] == fcs_pkg::KEY_DISABLE)) begin
          key_d = wd_q[7:4];
        end
      end else if (aw_q == fcs_pkg::REG_FADDR) begin
        if (ws_q[0]) faddr_d[7:0] = wd_q[7:0];
        if (ws_q[1]) faddr_d[15:8] = wd_q[15:8];
        if (ws_q[2]) faddr_d[19:16] = wd_q[19:16];
      end else if (aw_q == fcs_pkg::REG_FWDATA) begin
        if (ws_q[0]) fwdata_d = wd_q[7:0];
      end else if (aw_q != fcs_pkg::REG_FCMD) begin
        bresp_d = fcs_pkg::RESP_SLVERR;
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_comb begin
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    rd_pend_d = rd_pend_q;
    if (do_rd) begin
      rvalid_d = 1'b1;
      rresp_d  = fcs_pkg::RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      if (s_axi_araddr == fcs_pkg::REG_CTRL) begin
        rdata_d[7:4] = key_q;
      end else if (s_axi_araddr == fcs_pkg::REG_STATUS) begin
        rdata_d[3:0] = {secured, id_mode_q, busy, st_q != S_IDLE};
      end else if (s_axi_araddr == fcs_pkg::REG_FADDR) begin
        rdata_d[19:0] = faddr_q;
      end else if (s_axi_araddr == fcs_pkg::REG_FWDATA) begin
        rdata_d[7:0] = fwdata_q;
      end else if (s_axi_araddr == fcs_pkg::REG_FRDATA) begin
        rdata_d[7:0] = frdata_q;
      end else if (s_axi_araddr != fcs_pkg::REG_FCMD) begin
        rresp_d = fcs_pkg::RESP_SLVERR;
      end
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_q    <= 1'b0;
      aw_q       <= 8'h00;
      w_ok_q     <= 1'b0;
      wd_q       <= 32'h0000_0000;
      ws_q       <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= fcs_pkg::RESP_OKAY;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= fcs_pkg::RESP_OKAY;
      rd_pend_q  <= 1'b0;
      key_q      <= fcs_pkg::KEY_DISABLE;
      faddr_q    <= 20'h00000;
      fwdata_q   <= 8'h00;
      frdata_q   <= 8'h00;
      st_q       <= S_IDLE;
      id_mode_q  <= 1'b0;
      tog_q      <= 1'b1;
      job_q      <= '{start: 1'b0, op: fcs_pkg::OP_NONE, addr: 20'h00000, data: 8'h00};
      rd_phase_q <= 1'b0;
    end else if (ce) begin
      aw_ok_q    <= aw_ok_d;
      aw_q       <= aw_d;
      w_ok_q     <= w_ok_d;
      wd_q       <= wd_d;
      ws_q       <= ws_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      rd_pend_q  <= rd_pend_d;
      key_q      <= key_d;
      faddr_q    <= faddr_d;
      fwdata_q   <= fwdata_d;
      frdata_q   <= frdata_d;
      st_q       <= st_d;
      id_mode_q  <= id_mode_d;
      tog_q      <= tog_d;
      job_q      <= job_d;
      rd_phase_q <= rd_phase_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;
  assign flash_busy   = busy;
endmodule

// ### fcs_top_props.sv
// bus and busy-flag checks for the flash command sequencer
`timescale 1ns/1ps
module fcs_top_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       ce,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       flash_busy
);
  localparam int BUSY_MAX = 1500000;
  logic [20:0] run_q;
  logic [20:0] run_d;
  always_comb run_d = flash_busy ? run_q + 21'h1 : 21'h0;
  always_ff @(posedge aclk) run_q <= aresetn ? run_d : 21'h0;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence aw_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  read_answer_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rresp)) else $error("read answer dropped");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  write_answer_a: assert property (aw_w_take |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  stall_gate_a: assert property (!ce |-> !(s_axi_awready || s_axi_wready || s_axi_arready))
    else $error("ready while stalled");
  unmapped_read_a: assert property (ar_take ##0 s_axi_araddr > fcs_pkg::REG_FRDATA
    |=> s_axi_rresp == fcs_pkg::RESP_SLVERR) else $error("unmapped read not refused");
  busy_bound_a: assert property (run_q <= BUSY_MAX)
    else $error("operation too long");
  rvalid_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
endmodule
bind fcs_top fcs_top_props u_fcs_top_props (.*);

// ### fcs_cpu_model.sv
// cpu core model: axi4-lite master issuing flash bus cycles
`timescale 1ns/1ps
module fcs_cpu_model (
  input  wire logic   aclk,
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  wire logic   s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  wire logic   s_axi_wready,
  input  wire logic   s_axi_bvalid,
  output logic        s_axi_bready,
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  wire logic   s_axi_arready,
  input  wire logic   s_axi_rvalid,
  output logic        s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic cyc(input logic [19:0] a, input logic [7:0] d);
    wr(fcs_pkg::REG_FADDR, {12'h000, a});
    wr(fcs_pkg::REG_FWDATA, {24'h000000, d});
    wr(fcs_pkg::REG_FCMD, 32'h00000001);
  endtask
  task automatic cmd(input logic [7:0] c);
    cyc(fcs_pkg::UNLOCK_A, fcs_pkg::D_UNLOCK1);
    cyc(fcs_pkg::UNLOCK_B, fcs_pkg::D_UNLOCK2);
    cyc(fcs_pkg::UNLOCK_A, c);
  endtask
  task automatic fread(input logic [19:0] a);
    wr(fcs_pkg::REG_FADDR, {12'h000, a});
    wr(fcs_pkg::REG_FCMD, 32'h00000002);
    rd(fcs_pkg::REG_FRDATA);
  endtask
endmodule

// ### flash_command_sequencer_test.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module flash_command_sequencer_test;
  logic        aclk, aresetn, ce, flash_busy;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, fd;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0] exp_q[$], msk_q[$], msk_v;
  logic [19:0] fa;
  int          num_errors, comparisons, n, busy_n, busy_len;
  fcs_top u_fcs_top (.*);
  fcs_cpu_model cpu (.*);
  task automatic check(input logic [33:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [33:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    cpu.rd(a);
  endtask
  task automatic st(input logic [3:0] e, m);
    rchk(fcs_pkg::REG_STATUS, {30'h0, e}, {30'h0, m});
  endtask
  task automatic fchk(input logic [7:0] e);
    exp_q.push_back({26'h0, e});
    msk_q.push_back(34'h0_0000_00ff);
    cpu.fread(fa);
  endtask
  task automatic idle_wait;
    n = 0;
    while (flash_busy && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    @(posedge aclk);
    check(34'(busy_len <= fcs_pkg::PROG_CYC && n < 3000), 34'h1);
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    busy_n <= flash_busy ? busy_n + 1 : 0;
    if (!flash_busy && busy_n > 0)
      busy_len <= busy_n;
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
      msk_v = msk_q.pop_front();
      check({s_axi_rresp, s_axi_rdata} & msk_v, exp_q.pop_front() & msk_v);
    end
  end
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    complete_run;
  end
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    n = $urandom(32'h3b82);
    fa = fcs_pkg::WIN0_LO + 20'($urandom_range(255, 0));
    fd = 8'($urandom);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    ce <= 1'b0;
    repeat (2) @(posedge aclk);
    ce <= 1'b1;
    rchk(fcs_pkg::REG_CTRL, 34'h0_0000_00c0, 34'h3_0000_00f0);
    rchk(8'h40, {fcs_pkg::RESP_SLVERR, 32'h0}, 34'h3_0000_0000);
    cpu.cmd(fcs_pkg::C_PROGRAM);
    cpu.cyc(fa, fd);
    st(4'h0, 4'h2);
    $display("key lock test done");
    cpu.wr(fcs_pkg::REG_CTRL, 32'h00000030);
    cpu.cyc(fcs_pkg::UNLOCK_A, fcs_pkg::D_UNLOCK1);
    cpu.cyc(fcs_pkg::UNLOCK_B, 8'h00);
    cpu.cyc(fa, fd);
    st(4'h0, 4'h3);
    $display("broken sequence test done");
    cpu.cmd(fcs_pkg::C_PROGRAM);
    cpu.cyc(fa, fd);
    st(4'h2, 4'h2);
    fchk(8'h40);
    fchk(8'h00);
    idle_wait;
    fchk(fd);
    fchk(fd);
    $display("program test done");
    cpu.cmd(fcs_pkg::C_SECURITY);
    cpu.cyc(fcs_pkg::SECURE_ADDR, fcs_pkg::D_SECURE);
    fchk(8'h40);
    idle_wait;
    st(4'h8, 4'ha);
    cpu.cmd(fcs_pkg::C_ID_ENTRY);
    st(4'h4, 4'h4);
    cpu.cyc(fa, fcs_pkg::C_ID_EXIT);
    st(4'h0, 4'h4);
    $display("security and id test done");
    cpu.cmd(fcs_pkg::C_ERASE);
    cpu.cyc(fcs_pkg::UNLOCK_A, fcs_pkg::D_UNLOCK1);
    cpu.cyc(fcs_pkg::UNLOCK_B, fcs_pkg::D_UNLOCK2);
    cpu.cyc(20'h05123, fcs_pkg::C_SECTOR);
    st(4'h2, 4'h2);
    cpu.wr(fcs_pkg::REG_CTRL, 32'h000000c0);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    st(4'h0, 4'h2);
    $display("erase and reset test done");
    complete_run;
  end
endmodule
